// ===== src/scpm_defs.svh
// Offsets, reset values and fixed codes of the split commitment registers.
// Assumes byte addresses within the configuration space of one function.
`ifndef SCPM_DEFS_SVH
`define SCPM_DEFS_SVH
// -------------------------------------------------------------------------
// Register offsets
// -------------------------------------------------------------------------
`define SCPM_UP_OFF    8'h88
`define SCPM_DN_OFF    8'h8c
`define SCPM_PM_OFF    8'h90
// -------------------------------------------------------------------------
// Field values
// -------------------------------------------------------------------------
`define SCPM_CAP_VAL   16'h0010
`define SCPM_LIM_RST   16'h0010
`define SCPM_LIM_ANY   16'hffff
`define SCPM_PM_ID     8'h01
`define SCPM_NEXT_PTR  8'ha8
`define SCPM_LIM_LSB   16
`endif

// ===== src/scpm_pkg.sv
// Types shared by the split commitment register bank.
// Assumes the defs header is on the include path.
package scpm_pkg;
  // ADQ count, used for limits, sizes and outstanding totals
  typedef logic [15:0] scpm_adq_t;
  // Configuration dword
  typedef logic [31:0] scpm_dword_t;
endpackage

// ===== src/scpm_dir_if.sv
// Signals between the register bank and one direction's tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface scpm_dir_if;
  import scpm_pkg::*;
  scpm_adq_t limit;       // Programmed commitment limit
  logic      req_valid;   // Split request waiting to go out
  scpm_adq_t req_size;    // Its sequence size in ADQs
  logic      grant;       // Request may be forwarded now
  logic      cpl_valid;   // Completion space handed back
  scpm_adq_t cpl_size;    // Amount handed back in ADQs
  logic      delayed;     // Sticky held-back flag
  logic      delayed_clr; // Clear pulse for the flag
  modport track (input limit, req_valid, req_size, cpl_valid, cpl_size,
                 delayed_clr, output grant, delayed);
  modport ctrl  (output limit, req_valid, req_size, cpl_valid, cpl_size,
                 delayed_clr, input grant, delayed);
endinterface
`default_nettype wire

// ===== src/scpm_tracker.sv
// Outstanding split total and forwarding gate for one direction.
// Assumes asynchronous active-low reset already released cleanly.
`timescale 1ns/10ps
`default_nettype none
module scpm_tracker
  import scpm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  scpm_dir_if.track dir
);
  `include "scpm_defs.svh"
  // -----------------------------------------------------------------------
  // Room check
  // -----------------------------------------------------------------------
  scpm_adq_t   outstanding;      // ADQs committed but not returned
  logic [16:0] want;             // Total after this request
  logic        unbounded;        // Limit says no bound
  logic        fits;             // Request fits under limit
  scpm_adq_t   next_outstanding; // Next committed total
  logic [16:0] sum_add;          // Saturation helper
  scpm_adq_t   after_add;        // Total after grant
  assign want      = {1'b0, outstanding} + {1'b0, dir.req_size};
  assign unbounded = (dir.limit == `SCPM_LIM_ANY); // R6
  assign fits      = unbounded || (want <= {1'b0, dir.limit}); // R4
  assign dir.grant = dir.req_valid && fits; // R10
  assign sum_add   = dir.grant ? want : {1'b0, outstanding};
  assign after_add = sum_add[16] ? 16'hffff : sum_add[15:0];
  // Return of space, never below zero
  assign next_outstanding = !dir.cpl_valid ? after_add :
                            (dir.cpl_size >= after_add) ? 16'h0000 :
                            after_add - dir.cpl_size;
  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  // Committed total
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      outstanding <= 16'h0000;
    else
      outstanding <= next_outstanding; // R4
  end
  // Sticky delayed flag, a new refusal beats the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dir.delayed <= 1'b0;
    else if (dir.req_valid && !fits)
      dir.delayed <= 1'b1; // R10
    else if (dir.delayed_clr)
      dir.delayed <= 1'b0;
  end
  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  sequence refused_s;
    dir.req_valid && !dir.grant;
  endsequence
  sequence flagged_s;
    dir.delayed [*2];
  endsequence
  any_size_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    dir.req_valid && unbounded |-> dir.grant)
    else $error("unbounded limit refused a request");
  held_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    refused_s ##1 refused_s |-> flagged_s)
    else $error("refused request did not set sticky flag");
  over_limit_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    dir.req_valid && !unbounded && (want > {1'b0, dir.limit})
    |-> !dir.grant)
    else $error("request granted beyond limit");
  add_total_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    dir.grant && !dir.cpl_valid && !want[16] |=>
    outstanding == $past(want[15:0]))
    else $error("granted size not added to total");
endmodule
`default_nettype wire

// ===== src/scpm_regs.sv
// Split commitment limits and power management capability head.
// Assumes config accesses arrive on CLK from same-clock bus logic and
// that RST_N may be released at any time relative to CLK.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1 - Capability field reads fixed 0010h ADQs
// R2 - Offset 88h governs secondary-to-primary splits
// R3 - Offset 8Ch governs primary-to-secondary splits
// R4 - Bits 31:16 hold read-write commitment limit
// R5 - Any written 16-bit limit is applied
// R6 - Limit FFFFh forwards requests of any size
// R7 - Limits reset to 0010h
// R8 - Offset 90h bits 7:0 read 01h
// R9 - Offset 90h bits 15:8 read A8h
// R10 - Over-limit request held, sticky flag set
// R11 - Read-only fields ignore writes; byte enables honoured
module scpm_regs
  import scpm_pkg::*;
(
  input  wire  logic              CLK,
  input  wire  logic              RST_N,
  input  wire  logic [7:0]        CFG_ADDR,
  input  wire  logic              CFG_RD,
  input  wire  logic              CFG_WR,
  input  wire  logic [3:0]        CFG_BE,
  input  wire  scpm_pkg::scpm_dword_t CFG_WDATA,
  output var   scpm_pkg::scpm_dword_t CFG_RDATA,
  output logic                    CFG_RD_VALID,
  input  wire  logic              UP_REQ_VALID,
  input  wire  scpm_pkg::scpm_adq_t UP_REQ_SIZE,
  output logic                    UP_REQ_GRANT,
  input  wire  logic              UP_CPL_VALID,
  input  wire  scpm_pkg::scpm_adq_t UP_CPL_SIZE,
  output logic                    UP_DELAYED,
  input  wire  logic              UP_DELAYED_CLR,
  input  wire  logic              DN_REQ_VALID,
  input  wire  scpm_pkg::scpm_adq_t DN_REQ_SIZE,
  output logic                    DN_REQ_GRANT,
  input  wire  logic              DN_CPL_VALID,
  input  wire  scpm_pkg::scpm_adq_t DN_CPL_SIZE,
  output logic                    DN_DELAYED,
  input  wire  logic              DN_DELAYED_CLR
);
  import scpm_pkg::*;
  `include "scpm_defs.svh"
  // -----------------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------------
  logic [1:0] rst_pipe; // Release synchroniser
  logic       rst_n;    // Synchronised reset for the design
  // Two-stage release of the asynchronous reset
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];
  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Merge the two upper byte lanes into a limit field
  function automatic scpm_adq_t merge_limit(input scpm_adq_t   old_v,
                                            input scpm_dword_t wd,
                                            input logic [3:0]  be);
    scpm_adq_t r;
    r = old_v;
    if (be[2])
      r[7:0] = wd[23:16];
    if (be[3])
      r[15:8] = wd[31:24];
    return r;
  endfunction
  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  localparam logic [7:0] UP_OFF = `SCPM_UP_OFF; // Upstream dword
  localparam logic [7:0] DN_OFF = `SCPM_DN_OFF; // Downstream dword
  localparam logic [7:0] PM_OFF = `SCPM_PM_OFF; // PM capability head
  logic hit_up;          // Upstream register selected
  logic hit_dn;          // Downstream register selected
  logic hit_pm;          // PM head selected
  assign hit_up = (CFG_ADDR[7:2] == UP_OFF[7:2]);
  assign hit_dn = (CFG_ADDR[7:2] == DN_OFF[7:2]);
  assign hit_pm = (CFG_ADDR[7:2] == PM_OFF[7:2]);
  // -----------------------------------------------------------------------
  // Commitment limits
  // -----------------------------------------------------------------------
  scpm_adq_t up_limit;      // Secondary-to-primary limit
  scpm_adq_t dn_limit;      // Primary-to-secondary limit
  scpm_adq_t next_up_limit; // Upstream after write
  scpm_adq_t next_dn_limit; // Downstream after write
  assign next_up_limit = (CFG_WR && hit_up) ?
                         merge_limit(up_limit, CFG_WDATA, CFG_BE) :
                         up_limit; // R11
  assign next_dn_limit = (CFG_WR && hit_dn) ?
                         merge_limit(dn_limit, CFG_WDATA, CFG_BE) :
                         dn_limit; // R11
  // Limit storage, any value accepted
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_limit <= `SCPM_LIM_RST; // R7
      dn_limit <= `SCPM_LIM_RST; // R7
    end
    else
    begin
      up_limit <= next_up_limit; // R5
      dn_limit <= next_dn_limit; // R5
    end
  end
  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  scpm_dword_t rd_mux;     // Selected read word
  scpm_dword_t up_word;    // Upstream dword image
  scpm_dword_t dn_word;    // Downstream dword image
  scpm_dword_t pm_word;    // PM head image, upper half not held here
  assign up_word = {up_limit, `SCPM_CAP_VAL}; // R1
  assign dn_word = {dn_limit, `SCPM_CAP_VAL}; // R1
  assign pm_word = {16'h0000, `SCPM_NEXT_PTR, `SCPM_PM_ID}; // R8
  assign rd_mux  = hit_up ? up_word :
                   hit_dn ? dn_word :
                   hit_pm ? pm_word : 32'h0000_0000;
  // Registered read data, unmapped offsets read zero
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CFG_RDATA    <= 32'h0000_0000;
      CFG_RD_VALID <= 1'b0;
    end
    else
    begin
      CFG_RD_VALID <= CFG_RD;
      if (CFG_RD)
        CFG_RDATA <= rd_mux; // R9
    end
  end
  // -----------------------------------------------------------------------
  // Direction trackers
  // -----------------------------------------------------------------------
  scpm_dir_if up_dir ();   // Secondary requesters, primary completers
  scpm_dir_if dn_dir ();   // Primary requesters, secondary completers
  assign up_dir.limit       = up_limit; // R2
  assign up_dir.req_valid   = UP_REQ_VALID;
  assign up_dir.req_size    = UP_REQ_SIZE;
  assign up_dir.cpl_valid   = UP_CPL_VALID;
  assign up_dir.cpl_size    = UP_CPL_SIZE;
  assign up_dir.delayed_clr = UP_DELAYED_CLR;
  assign UP_REQ_GRANT       = up_dir.grant;
  assign UP_DELAYED         = up_dir.delayed;
  assign dn_dir.limit       = dn_limit; // R3
  assign dn_dir.req_valid   = DN_REQ_VALID;
  assign dn_dir.req_size    = DN_REQ_SIZE;
  assign dn_dir.cpl_valid   = DN_CPL_VALID;
  assign dn_dir.cpl_size    = DN_CPL_SIZE;
  assign dn_dir.delayed_clr = DN_DELAYED_CLR;
  assign DN_REQ_GRANT       = dn_dir.grant;
  assign DN_DELAYED         = dn_dir.delayed;
  scpm_tracker u_up_track
  (
    .clk   (CLK),
    .rst_n (rst_n),
    .dir   (up_dir.track)
  );
  scpm_tracker u_dn_track
  (
    .clk   (CLK),
    .rst_n (rst_n),
    .dir   (dn_dir.track)
  );
  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  // Both split dwords answer with the fixed capability
  cap_read_a: assert property (@(posedge CLK) disable iff (!rst_n) // R1
    CFG_RD && (hit_up || hit_dn) |=> CFG_RD_VALID &&
    CFG_RDATA[15:0] == `SCPM_CAP_VAL)
    else $error("capability field misread");
  // Low byte of the capability head is the fixed id
  pm_id_read_a: assert property (@(posedge CLK) disable iff (!rst_n) // R8
    CFG_RD && hit_pm |=> CFG_RDATA[7:0] == `SCPM_PM_ID)
    else $error("power capability id misread");
  // Second byte links on to the next capability
  next_ptr_read_a: assert property (@(posedge CLK) disable iff (!rst_n) // R9
    CFG_RD && hit_pm |=> CFG_RDATA[15:8] == `SCPM_NEXT_PTR)
    else $error("next capability link misread");
  // Limits leave reset at the real buffer size
  limit_reset_a: assert property (@(posedge CLK) // R7
    $rose(rst_n) |-> up_limit == `SCPM_LIM_RST &&
    dn_limit == `SCPM_LIM_RST)
    else $error("limit not at reset value");
  // Full write lands, then holds for the next cycle unless written again
  limit_write_a: assert property (@(posedge CLK) disable iff (!rst_n) // R5
    CFG_WR && hit_up && CFG_BE[3:2] == 2'b11 |=>
    up_limit == $past(CFG_WDATA[31:16]) ##1
    (($past(CFG_WR) && $past(hit_up)) || up_limit == $past(up_limit)))
    else $error("written upstream limit not applied");
  // Only the enabled lane of the limit moves
  lane_mask_a: assert property (@(posedge CLK) disable iff (!rst_n) // R11
    CFG_WR && hit_dn && CFG_BE[3:2] == 2'b01 |=>
    dn_limit[15:8] == $past(dn_limit[15:8]) &&
    dn_limit[7:0] == $past(CFG_WDATA[23:16]))
    else $error("byte enables not honoured on limit");
  // Lanes off, so the limit stays as it was
  lane_keep_a: assert property (@(posedge CLK) disable iff (!rst_n) // R11
    CFG_WR && hit_up && CFG_BE[3:2] == 2'b00 |=>
    up_limit == $past(up_limit))
    else $error("limit changed with its lanes disabled");
  // Full downstream write applies the whole limit
  dn_write_a: assert property (@(posedge CLK) disable iff (!rst_n) // R3
    CFG_WR && hit_dn && CFG_BE[3:2] == 2'b11 |=>
    dn_limit == $past(CFG_WDATA[31:16]))
    else $error("written downstream limit not applied");
  // Open upstream limit opens the upstream gate
  up_steer_a: assert property (@(posedge CLK) disable iff (!rst_n) // R2
    UP_REQ_VALID && up_limit == `SCPM_LIM_ANY |-> UP_REQ_GRANT)
    else $error("upstream limit does not steer upstream gate");
  // Upstream refusal raises the upstream flag
  up_refuse_a: assert property (@(posedge CLK) disable iff (!rst_n) // R2
    UP_REQ_VALID && !UP_REQ_GRANT |=> UP_DELAYED)
    else $error("upstream refusal not flagged");
  // Downstream refusal raises the downstream flag
  dn_steer_a: assert property (@(posedge CLK) disable iff (!rst_n) // R3
    DN_REQ_VALID && !DN_REQ_GRANT |=> DN_DELAYED)
    else $error("downstream refusal not flagged");
endmodule
`default_nettype wire

// ===== bench/scpm_partner.sv
// Requester and completer pair on one side of a forwarding direction.
// Assumes the bench pulses start and ret on rising CLK edges.
`timescale 1ns/10ps
`default_nettype none
module scpm_partner
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire scpm_pkg::scpm_adq_t  size,
  input  wire logic                 ret,
  input  wire scpm_pkg::scpm_adq_t  ret_size,
  input  wire logic                 grant,
  output var  logic                 req_valid,
  output var  scpm_pkg::scpm_adq_t  req_size,
  output var  logic                 cpl_valid,
  output var  scpm_pkg::scpm_adq_t  cpl_size
);
  import scpm_pkg::*;
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  scpm_adq_t last_sz; // Size of the latest request
  scpm_adq_t last_rs; // Size of the latest return
  // Idle buses show the inverse so stale values never pass
  assign req_size = req_valid ? last_sz : ~last_sz;
  assign cpl_size = cpl_valid ? last_rs : ~last_rs;
  // Request held until the bridge grants it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_valid <= 1'b0;
      last_sz   <= 16'h0000;
    end
    else if (start)
    begin
      req_valid <= 1'b1;
      last_sz   <= size;
    end
    else if (req_valid && grant)
      req_valid <= 1'b0;
  end
  // Completion hands space back for one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpl_valid <= 1'b0;
      last_rs   <= 16'h0000;
    end
    else
    begin
      cpl_valid <= ret;
      if (ret)
        last_rs <= ret_size;
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the split commitment register bank.
// Assumes the design files and defs header are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import scpm_pkg::*;
  // -----------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  CFG_ADDR = 8'h00;
  logic        CFG_RD = 1'b0;
  logic        CFG_WR = 1'b0;
  logic [3:0]  CFG_BE = 4'h0;
  scpm_dword_t CFG_WDATA = 32'h0;
  scpm_dword_t CFG_RDATA;
  logic        CFG_RD_VALID;
  logic [1:0]  start = 2'h0, ret = 2'h0, clr = 2'h0;
  scpm_adq_t   sz [2] = '{16'h0, 16'h0};
  scpm_adq_t   rsz [2] = '{16'h0, 16'h0};
  wire  [1:0]  vld, gnt, cv, dly;
  scpm_adq_t   qs [2];
  scpm_adq_t   cs [2];
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // -----------------------------------------------------------------
  // Clock, timeout, instances
  // -----------------------------------------------------------------
  always #25 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt = error_cnt + 1;
      summarize();
    end
  end
  scpm_partner u_up (.clk(CLK), .rst_n(RST_N), .start(start[0]),
    .size(sz[0]), .ret(ret[0]), .ret_size(rsz[0]), .grant(gnt[0]),
    .req_valid(vld[0]), .req_size(qs[0]), .cpl_valid(cv[0]),
    .cpl_size(cs[0]));
  scpm_partner u_dn (.clk(CLK), .rst_n(RST_N), .start(start[1]),
    .size(sz[1]), .ret(ret[1]), .ret_size(rsz[1]), .grant(gnt[1]),
    .req_valid(vld[1]), .req_size(qs[1]), .cpl_valid(cv[1]),
    .cpl_size(cs[1]));
  scpm_regs i_scpm_regs (.CLK(CLK), .RST_N(RST_N), .CFG_ADDR(CFG_ADDR),
    .CFG_RD(CFG_RD), .CFG_WR(CFG_WR), .CFG_BE(CFG_BE),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .CFG_RD_VALID(CFG_RD_VALID), .UP_REQ_VALID(vld[0]),
    .UP_REQ_SIZE(qs[0]), .UP_REQ_GRANT(gnt[0]), .UP_CPL_VALID(cv[0]),
    .UP_CPL_SIZE(cs[0]), .UP_DELAYED(dly[0]), .UP_DELAYED_CLR(clr[0]),
    .DN_REQ_VALID(vld[1]), .DN_REQ_SIZE(qs[1]), .DN_REQ_GRANT(gnt[1]),
    .DN_CPL_VALID(cv[1]), .DN_CPL_SIZE(cs[1]), .DN_DELAYED(dly[1]),
    .DN_DELAYED_CLR(clr[1]));
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task automatic summarize();
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("Error %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One configuration write
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
                        input scpm_dword_t d);
    @(posedge CLK);
    CFG_WR    <= 1'b1;
    CFG_ADDR  <= a;
    CFG_BE    <= be;
    CFG_WDATA <= d;
    @(posedge CLK);
    CFG_WR    <= 1'b0;
  endtask
  // One configuration read, judged in the answer cycle
  task automatic cfg_rd(input logic [7:0] a, input scpm_dword_t exp);
    @(posedge CLK);
    CFG_RD   <= 1'b1;
    CFG_ADDR <= a;
    @(posedge CLK);
    CFG_RD   <= 1'b0;
    #1;
    chk({31'h0, CFG_RD_VALID}, 32'h1, "read answer");
    chk(CFG_RDATA, exp, "read data");
  endtask
  // Issue a request and see whether it goes out
  task automatic send(input int d, input scpm_adq_t s, input logic go);
    int n;
    @(posedge CLK);
    start[d] <= 1'b1;
    sz[d]    <= s;
    @(posedge CLK);
    start[d] <= 1'b0;
    n = 0;
    do
    begin
      @(posedge CLK);
      #1;
      n++;
    end while (vld[d] && n < 6);
    chk({31'h0, ~vld[d]}, {31'h0, go}, "forwarded");
  endtask
  // Hand completion space back
  task automatic give_back(input int d, input scpm_adq_t s);
    @(posedge CLK);
    ret[d] <= 1'b1;
    rsz[d] <= s;
    @(posedge CLK);
    ret[d] <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
  endtask
  // One-cycle clear pulse for a direction's flag
  task automatic pulse_clr(input int d);
    @(posedge CLK);
    clr[d] <= 1'b1;
    @(posedge CLK);
    clr[d] <= 1'b0;
    #1;
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset_vals();
    cfg_rd(8'h88, 32'h00100010);
    cfg_rd(8'h8c, 32'h00100010);
    cfg_rd(8'h90, 32'h0000a801);
  endtask
  task automatic t_ro_write();
    cfg_wr(8'h90, 4'hf, 32'hffffffff);
    cfg_wr(8'h88, 4'h3, 32'h0000ffff);
    cfg_wr(8'h40, 4'hf, 32'hffffffff);
    cfg_rd(8'h90, 32'h0000a801);
    cfg_rd(8'h88, 32'h00100010);
    cfg_rd(8'h40, 32'h00000000);
  endtask
  task automatic t_byte_lanes();
    cfg_wr(8'h8c, 4'h4, 32'h12345678);
    cfg_rd(8'h8c, 32'h00340010);
    cfg_wr(8'h8c, 4'h8, 32'hab000000);
    cfg_rd(8'h8c, 32'hab340010);
  endtask
  task automatic t_gate();
    send(0, 16'h0010, 1'b1);
    send(0, 16'h0001, 1'b0);
    chk({30'h0, dly}, 32'h1, "held flag");
    give_back(0, 16'h0010);
    chk({31'h0, vld[0]}, 32'h0, "late grant");
    chk({31'h0, dly[0]}, 32'h1, "sticky flag");
    pulse_clr(0);
    chk({31'h0, dly[0]}, 32'h0, "flag cleared");
    give_back(0, 16'h0001);
  endtask
  task automatic t_open_limit();
    cfg_wr(8'h8c, 4'hc, 32'hffff0000);
    send(1, 16'hffff, 1'b1);
    send(1, 16'hffff, 1'b1);
    cfg_wr(8'h88, 4'hc, 32'h00000000);
    cfg_rd(8'h88, 32'h00000010);
    send(0, 16'h0001, 1'b0);
  endtask
  task automatic t_dn_hold();
    cfg_wr(8'h8c, 4'hc, 32'h00100000);
    send(1, 16'h0001, 1'b0);
    pulse_clr(1);
    chk({31'h0, dly[1]}, 32'h1, "clear during refusal");
    give_back(1, 16'hffff);
    chk({31'h0, vld[1]}, 32'h0, "late grant down");
    pulse_clr(1);
    chk({31'h0, dly[1]}, 32'h0, "down flag cleared");
    cfg_wr(8'h88, 4'hc, 32'hffff0000);
    repeat (2) @(posedge CLK);
    #1;
    chk({31'h0, vld[0]}, 32'h0, "open upstream");
  endtask
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset_vals();
    t_ro_write();
    t_byte_lanes();
    t_gate();
    t_open_limit();
    t_dn_hold();
    summarize();
  end
endmodule
`default_nettype wire
